/* File: apr_defines.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the page register group.
// Assumes: Sixteen-bit registers, word index addressing per port.
// Notes: Definitions only.
`ifndef APR_DEFINES_SVH
`define APR_DEFINES_SVH
`define APR_OFF_EXP 5'h06
`define APR_OFF_NPTX 5'h07
`define APR_OFF_LPNP 5'h08
`define APR_OFF_GCTL 5'h09
`define APR_OFF_PORT_STAT 5'h1E
`define APR_EXP_PDF 4
`define APR_EXP_LPNPA 3
`define APR_EXP_NPA 2
`define APR_EXP_PRX 1
`define APR_EXP_LPANA 0
`define APR_NP_NEXT 15
`define APR_NP_ACK 14
`define APR_NP_MSG 13
`define APR_NP_ACK2 12
`define APR_NP_TOG 11
`define APR_NP_MSGF_HI 10
`define APR_GC_TEST_HI 15
`define APR_GC_TEST_LO 13
`define APR_GC_MSEN 12
`define APR_GC_MSVAL 11
`define APR_GC_PTYPE 10
`define APR_GC_FD 9
`define APR_GC_HD 8
`define APR_NPTX_RST 16'h2001
`define APR_GCTL_RST 16'h0700
`define APR_EXP_RSVD_RST 11'h000
`define APR_CLK_MHZ 25
`define APR_PAGE_NS 16
`define APR_PAGE_CYC ((`APR_PAGE_NS * `APR_CLK_MHZ + 999) / 1000 < 1 ? 1 : (`APR_PAGE_NS * `APR_CLK_MHZ + 999) / 1000)
`endif

/* File: apr_pkg.sv */
// Purpose: Types shared by the page register group.
// Assumes: Nothing beyond the defines header.
// Notes: Types only.
`default_nettype none
package apr_pkg;
   typedef enum logic [2:0] {
      APR_TM_NORMAL = 3'h0,
      APR_TM_WAVE = 3'h1,
      APR_TM_JIT_M = 3'h2,
      APR_TM_JIT_S = 3'h3,
      APR_TM_DIST = 3'h4
   } apr_test_t;
   typedef enum logic [2:0] {
      APR_MS_AUTO = 3'b001,
      APR_MS_MASTER = 3'b010,
      APR_MS_SLAVE = 3'b100
   } apr_ms_t;
endpackage
`default_nettype wire

/* File: apr_latch_flag.sv */
// Purpose: One latch-high status bit that holds an event until software reads it.
// Assumes: Read strobe is one cycle long.
// Notes: A new event in the read cycle wins over the clear.
`timescale 1ns/10ps
`default_nettype none
module apr_latch_flag (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_event,
   input wire logic i_rd_clr,
   output logic o_flag
);
   logic flag_r;
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         flag_r <= 1'b0;
      end else if (i_event) begin
         flag_r <= 1'b1;
      end else if (i_rd_clr) begin
         flag_r <= 1'b0;
      end
   end
   assign o_flag = flag_r | i_event;
endmodule // apr_latch_flag
`default_nettype wire

/* File: apr_test_gen.sv */
// Purpose: Drives a per-pair test pattern while a gigabit test mode is selected.
// Assumes: Pattern is symbolic; the analog front end shapes the waveform.
// Notes: Runs without any link partner.
`timescale 1ns/10ps
`default_nettype none
module apr_test_gen #(
   parameter int PAIRS = 4
) (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire apr_pkg::apr_test_t i_mode,
   output logic [PAIRS-1:0] o_pair_tx,
   output logic o_active
);
   import apr_pkg::*;
   logic [7:0] lfsr_r;
   logic [PAIRS-1:0] pair_r;
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn || i_mode == APR_TM_NORMAL) begin
         lfsr_r <= 8'h01;
      end else begin
         lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
      end
   end
   genvar g;
   generate
      for (g = 0; g < PAIRS; g++) begin : g_pair
         always_ff @(posedge i_clk_sys) begin
            if (!i_rstn || i_mode == APR_TM_NORMAL) begin
               pair_r[g] <= 1'b0;
            end else begin
               pair_r[g] <= lfsr_r[g] ^ (i_mode == APR_TM_JIT_S);
            end
         end
      end
   endgenerate
   assign o_pair_tx = pair_r;
   assign o_active = (i_mode != APR_TM_NORMAL);
endmodule // apr_test_gen
`default_nettype wire

/* File: apr_regs.sv */
// Purpose: Auto-negotiation expansion, next-page and gigabit control registers of one copper port.
// Assumes: One instance per port; the port number in the address picks the instance outside.
// Notes: Register index is the low address; read data stands one cycle after the read strobe.
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "apr_defines.svh"
module apr_regs #(
   parameter int PAIRS = 4,
   parameter int AW = 5
) (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic [AW-1:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [15:0] o_rdata,
   input wire logic i_pd_fault,
   input wire logic i_lp_np_able,
   input wire logic i_lp_an_able,
   input wire logic i_page_rx,
   input wire logic [15:0] i_lp_np_word,
   input wire logic i_np_sent,
   input wire logic i_gig_forced,
   output logic [15:0] o_np_tx_word,
   output logic o_adv_fd,
   output logic o_adv_hd,
   output logic o_port_pref_master,
   output apr_pkg::apr_ms_t o_ms_mode,
   output apr_pkg::apr_test_t o_test_mode,
   output logic o_test_active,
   output logic [PAIRS-1:0] o_pair_tx
);
   import apr_pkg::*;

   logic [15:0] nptx_r;
   logic tog_r;
   logic [15:0] lpnp_r;
   logic [15:0] gctl_r;
   logic [15:0] rdata_r;
   logic pdf_flag;
   logic prx_flag;
   logic rd_exp;
   logic [15:0] exp_val;
   apr_ms_t ms_r;
   apr_test_t test_eff;

   // Only the register index is decoded here; the port number is decoded outside, one instance per port.
   function automatic logic hit(input logic [AW-1:0] a, input logic [AW-1:0] off);
      hit = (a == off);
   endfunction

   assign rd_exp = i_rd && hit(i_addr, AW'(`APR_OFF_EXP));

   // Reading the expansion register clears both latched flags together.
   apr_latch_flag u_pdf (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_event(i_pd_fault),
      .i_rd_clr(rd_exp),
      .o_flag(pdf_flag)
   );
   apr_latch_flag u_prx (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_event(i_page_rx),
      .i_rd_clr(rd_exp),
      .o_flag(prx_flag)
   );

   always_comb begin
      exp_val = 16'h0000;
      exp_val[`APR_EXP_PDF] = pdf_flag;
      exp_val[`APR_EXP_LPNPA] = i_lp_np_able;
      exp_val[`APR_EXP_NPA] = 1'b1;
      exp_val[`APR_EXP_PRX] = prx_flag;
      exp_val[`APR_EXP_LPANA] = i_lp_an_able;
   end

   // Writable next-page fields; bit 14 and the toggle are not stored from software.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         nptx_r <= `APR_NPTX_RST;
      end else if (i_wr && hit(i_addr, AW'(`APR_OFF_NPTX))) begin
         nptx_r[`APR_NP_NEXT] <= i_wdata[`APR_NP_NEXT];
         nptx_r[`APR_NP_MSG] <= i_wdata[`APR_NP_MSG];
         nptx_r[`APR_NP_ACK2] <= i_wdata[`APR_NP_ACK2];
         nptx_r[`APR_NP_MSGF_HI:0] <= i_wdata[`APR_NP_MSGF_HI:0];
      end
   end

   // The toggle follows each sent page so the next word alternates.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         tog_r <= 1'b0;
      end else if (i_np_sent) begin
         tog_r <= ~tog_r;
      end
   end

   always_comb begin
      o_np_tx_word = nptx_r;
      o_np_tx_word[`APR_NP_ACK] = 1'b0;
      o_np_tx_word[`APR_NP_TOG] = tog_r;
   end

   // Partner word captured on each received page, with its toggle bit 11 stored inverted.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         lpnp_r <= 16'h0000;
      end else if (i_page_rx) begin
         lpnp_r <= i_lp_np_word;
         lpnp_r[`APR_NP_TOG] <= ~i_lp_np_word[`APR_NP_TOG];
      end
   end

   // Reserved test codes are kept as written but behave as normal operation.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         gctl_r <= `APR_GCTL_RST;
      end else if (i_wr && hit(i_addr, AW'(`APR_OFF_GCTL))) begin
         gctl_r[15:8] <= i_wdata[15:8];
      end
   end

   always_comb begin
      test_eff = APR_TM_NORMAL;
      if (i_gig_forced && gctl_r[`APR_GC_TEST_HI:`APR_GC_TEST_LO] <= 3'h4) begin
         test_eff = apr_test_t'(gctl_r[`APR_GC_TEST_HI:`APR_GC_TEST_LO]);
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         ms_r <= APR_MS_AUTO;
      end else begin
         case (gctl_r[`APR_GC_MSEN:`APR_GC_MSVAL])
            2'b11: ms_r <= APR_MS_MASTER;
            2'b10: ms_r <= APR_MS_SLAVE;
            default: ms_r <= APR_MS_AUTO;
         endcase
      end
   end

   assign o_ms_mode = ms_r;
   assign o_port_pref_master = gctl_r[`APR_GC_PTYPE] & ~gctl_r[`APR_GC_MSEN];
   assign o_adv_fd = gctl_r[`APR_GC_FD];
   assign o_adv_hd = gctl_r[`APR_GC_HD];
   assign o_test_mode = test_eff;

   apr_test_gen #(.PAIRS(PAIRS)) u_tgen (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .i_mode(test_eff),
      .o_pair_tx(o_pair_tx),
      .o_active(o_test_active)
   );

   // Unmapped offsets read zero; the status word is an extra view of live state.
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         rdata_r <= 16'h0000;
      end else if (i_rd) begin
         if (hit(i_addr, AW'(`APR_OFF_EXP))) begin
            rdata_r <= exp_val;
         end else if (hit(i_addr, AW'(`APR_OFF_NPTX))) begin
            rdata_r <= o_np_tx_word;
         end else if (hit(i_addr, AW'(`APR_OFF_LPNP))) begin
            rdata_r <= lpnp_r;
         end else if (hit(i_addr, AW'(`APR_OFF_GCTL))) begin
            rdata_r <= {gctl_r[15:8], 8'h00};
         end else if (hit(i_addr, AW'(`APR_OFF_PORT_STAT))) begin
            // Eight zero bits, active, forced, three test bits and three mode bits fill the word exactly.
            rdata_r <= {8'h00, o_test_active, i_gig_forced, test_eff, ms_r};
         end else begin
            rdata_r <= 16'h0000;
         end
      end
   end
   assign o_rdata = rdata_r;

   reg_rst_a: assert property (@(posedge i_clk_sys) !i_rstn |=> nptx_r == 16'h2001 && gctl_r == 16'h0700)
      else $error("Register reset values wrong.");
   exp_rsvd_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      $past(rd_exp) |-> o_rdata[15:5] == 11'h000 && o_rdata[2]) else $error("Expansion reserved or bit 2 wrong.");
   pdf_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      i_pd_fault ##1 (!rd_exp)[*2] |-> pdf_flag) else $error("Fault flag not held.");
   prx_read_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      i_page_rx && !rd_exp ##1 rd_exp |=> o_rdata[1]) else $error("Page flag lost before read.");
   prx_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      rd_exp && !i_page_rx ##1 !i_page_rx |-> !prx_flag) else $error("Page flag not cleared by read.");
   lp_tog_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      i_page_rx |=> lpnp_r[11] != $past(i_lp_np_word[11]) && lpnp_r[10:0] == $past(i_lp_np_word[10:0]))
      else $error("Partner word capture wrong.");
   tog_flip_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      i_np_sent |=> o_np_tx_word[11] != $past(o_np_tx_word[11])) else $error("Toggle did not flip.");
   ms_force_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      gctl_r[12] && gctl_r[11] ##1 $stable(gctl_r[12:11]) |-> ms_r == APR_MS_MASTER)
      else $error("Manual master not applied.");
   test_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      !i_gig_forced || gctl_r[15:13] > 3'h4 |-> !o_test_active) else $error("Test mode without forcing.");
   test_pairs_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      test_eff == APR_TM_NORMAL |=> o_pair_tx == '0) else $error("Pairs active in normal mode.");

   pdf_cov_c: cover property (@(posedge i_clk_sys) i_pd_fault ##[1:4] rd_exp);
   page_cov_c: cover property (@(posedge i_clk_sys) i_page_rx ##1 i_np_sent);
   test_cov_c: cover property (@(posedge i_clk_sys) o_test_active [*3]);
   ms_cov_c: cover property (@(posedge i_clk_sys) ms_r == APR_MS_SLAVE);
endmodule // apr_regs
`default_nettype wire

/* File: apr_lp_model.sv */
// Purpose: Link partner model that drives page, toggle and fault events into one port.
// Assumes: Events are single-cycle pulses launched just after a rising edge.
// Notes: The page word is only meaningful with its pulse, so it is inverted afterwards.
`timescale 1ns/10ps
`default_nettype none
module apr_lp_model (
   input wire logic i_clk_sys,
   output logic o_page_rx,
   output logic [15:0] o_lp_np_word,
   output logic o_np_sent,
   output logic o_pd_fault,
   output logic o_np_able,
   output logic o_an_able
);
   initial begin
      o_page_rx = 1'b0;
      o_lp_np_word = 16'h5a5a;
      o_np_sent = 1'b0;
      o_pd_fault = 1'b0;
      o_np_able = 1'b0;
      o_an_able = 1'b0;
   end
   // Select bit 0 sends a page, bit 1 reports our page sent, bit 2 raises a fault.
   task automatic pulse(input logic [2:0] sel, input logic [15:0] w);
      @(posedge i_clk_sys);
      o_page_rx <= sel[0];
      o_np_sent <= sel[1];
      o_pd_fault <= sel[2];
      o_lp_np_word <= w;
      @(posedge i_clk_sys);
      o_page_rx <= 1'b0;
      o_np_sent <= 1'b0;
      o_pd_fault <= 1'b0;
      o_lp_np_word <= ~w;
   endtask
   task automatic set_able(input logic np, input logic an);
      @(posedge i_clk_sys);
      o_np_able <= np;
      o_an_able <= an;
   endtask
endmodule // apr_lp_model
`default_nettype wire

/* File: testbench.sv */
// Purpose: Self-checking bench for the page register group of one port.
// Assumes: Read data is compared in the cycle after the read strobe only.
// Notes: Expected read values queue up and are matched in issue order.
`timescale 1ns/10ps
`default_nettype none
`include "apr_defines.svh"
module testbench;
   import apr_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_rstn = 1'b0;
   logic [4:0] i_addr = 5'h00;
   logic [15:0] i_wdata = 16'h0000;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   logic i_gig_forced = 1'b0;
   logic rd_q = 1'b0;
   logic [15:0] o_rdata, o_np_tx_word, lp_word;
   logic page_rx, np_sent, pd_fault, np_able, an_able, o_adv_fd, o_adv_hd, o_port_pref_master, o_test_active;
   apr_ms_t o_ms_mode;
   apr_test_t o_test_mode;
   logic [3:0] o_pair_tx;
   logic [15:0] exp_q[$];
   logic [31:0] r;
   int bad_count = 0;
   int num_checks = 0;
   always #20 i_clk_sys = ~i_clk_sys;
   apr_lp_model u_apr_lp_model (.i_clk_sys(i_clk_sys), .o_page_rx(page_rx), .o_lp_np_word(lp_word),
      .o_np_sent(np_sent), .o_pd_fault(pd_fault), .o_np_able(np_able), .o_an_able(an_able));
   apr_regs u_apr_regs (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pd_fault(pd_fault), .i_lp_np_able(np_able),
      .i_lp_an_able(an_able), .i_page_rx(page_rx), .i_lp_np_word(lp_word), .i_np_sent(np_sent),
      .i_gig_forced(i_gig_forced), .o_np_tx_word(o_np_tx_word), .o_adv_fd(o_adv_fd), .o_adv_hd(o_adv_hd),
      .o_port_pref_master(o_port_pref_master), .o_ms_mode(o_ms_mode), .o_test_mode(o_test_mode),
      .o_test_active(o_test_active), .o_pair_tx(o_pair_tx));
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(posedge i_clk_sys);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [15:0] e);
      @(posedge i_clk_sys);
      exp_q.push_back(e);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
   endtask
   // Read data is updated in the cycle after the strobe, so it is sampled mid-cycle there.
   always @(posedge i_clk_sys) rd_q <= i_rd;
   always @(negedge i_clk_sys) begin
      if (rd_q) check("rdata", o_rdata, exp_q.pop_front());
   end
   initial begin
      repeat (3000) @(posedge i_clk_sys);
      bad_count++;
      summarize();
   end
   initial begin
      void'($urandom(96630));
      repeat (4) @(posedge i_clk_sys);
      i_rstn <= 1'b1;
      rd(`APR_OFF_EXP, 16'h0004);
      rd(`APR_OFF_NPTX, `APR_NPTX_RST);
      rd(`APR_OFF_LPNP, 16'h0000);
      rd(`APR_OFF_GCTL, `APR_GCTL_RST);
      rd(5'h1F, 16'h0000);
      wr(`APR_OFF_EXP, 16'hFFFF);
      wr(`APR_OFF_LPNP, 16'hFFFF);
      rd(`APR_OFF_EXP, 16'h0004);
      rd(`APR_OFF_LPNP, 16'h0000);
      wr(`APR_OFF_NPTX, 16'hFFFF);
      rd(`APR_OFF_NPTX, 16'hB7FF);
      u_apr_lp_model.pulse(3'b010, 16'h0000);
      rd(`APR_OFF_NPTX, 16'hBFFF);
      check("np_tx_word", o_np_tx_word, 16'hBFFF);
      wr(`APR_OFF_NPTX, 16'h0000);
      rd(`APR_OFF_NPTX, 16'h0800);
      r = $urandom;
      u_apr_lp_model.pulse(3'b001, r[15:0]);
      rd(`APR_OFF_EXP, 16'h0006);
      rd(`APR_OFF_EXP, 16'h0004);
      rd(`APR_OFF_LPNP, r[15:0] ^ 16'h0800);
      u_apr_lp_model.pulse(3'b100, 16'h0000);
      rd(`APR_OFF_EXP, 16'h0014);
      rd(`APR_OFF_EXP, 16'h0004);
      // A fault landing in the clearing read must not be lost.
      fork
         u_apr_lp_model.pulse(3'b100, 16'h0000);
         rd(`APR_OFF_EXP, 16'h0014);
      join
      rd(`APR_OFF_EXP, 16'h0014);
      rd(`APR_OFF_EXP, 16'h0004);
      u_apr_lp_model.set_able(1'b1, 1'b1);
      rd(`APR_OFF_EXP, 16'h000D);
      repeat (6) begin
         r = $urandom;
         wr(`APR_OFF_GCTL, r[15:0]);
         rd(`APR_OFF_GCTL, r[15:0] & 16'hFF00);
         @(negedge i_clk_sys);
         check("adv_fd", 16'(o_adv_fd), 16'(r[9]));
         check("adv_hd", 16'(o_adv_hd), 16'(r[8]));
         check("pref", 16'(o_port_pref_master), 16'(r[10] & ~r[12]));
         check("test_off", 16'(o_test_mode), 16'h0000);
         check("ms_mode", 16'(o_ms_mode), r[12] ? (r[11] ? 16'h0002 : 16'h0004) : 16'h0001);
      end
      i_gig_forced <= 1'b1;
      for (int c = 0; c < 8; c++) begin
         wr(`APR_OFF_GCTL, {c[2:0], 13'h0700});
         @(negedge i_clk_sys);
         check("test_mode", 16'(o_test_mode), (c < 5) ? 16'(c) : 16'h0000);
         check("test_active", 16'(o_test_active), 16'((c > 0) && (c < 5)));
      end
      wr(`APR_OFF_GCTL, 16'h0700);
      repeat (2) @(negedge i_clk_sys);
      check("pair_tx", 16'(o_pair_tx), 16'h0000);
      rd(`APR_OFF_PORT_STAT, 16'h0041);
      repeat (3) @(posedge i_clk_sys);
      summarize();
   end
endmodule // testbench
`default_nettype wire
